// File: design/fpk_map.svh
`ifndef FPK_MAP_SVH
`define FPK_MAP_SVH
// register byte offsets
`define FPK_ADDR_CTRL     4'h0
`define FPK_ADDR_STATUS   4'h4
`define FPK_ADDR_EVENT    4'h8
`define FPK_ADDR_CMD      4'hc
// field positions
`define FPK_CTRL_DEVNZ    0
`define FPK_EVT_SEC       5
`define FPK_EVT_PEND      8
`define FPK_CMD_SEC       5
// reset values
`define FPK_CTRL_RST      1'h0
// bus responses
`define FPK_RESP_OKAY     2'h0
`define FPK_RESP_SLVERR   2'h2
// keypad
`define FPK_NUM_KEYS      20
`define FPK_SYNC_W        22
`define FPK_PIN_REMOTE    20
`define FPK_PIN_CAL_OK    21
`define FPK_KEY_SHIFT     5'h0b
// ranges: voltage 0=20mV..5=1kV, current 0=200uA..5=10A
`define FPK_RANGE_LOWEST  3'h0
`define FPK_VR_HV_FIRST   3'h4
`define FPK_IR_HC_FIRST   3'h5
`define FPK_CAL_ERR_CODE  4'h6
// timing
`define FPK_CLK_MHZ       200
`define FPK_VERSION_MS    1000
`define FPK_BLINK_MS      250
`define FPK_DATA_MS       50
`endif

// File: design/fpk_pkg.sv
package fpk_pkg;
   typedef enum logic [1:0] {FPK_Q_VOLT, FPK_Q_CURR, FPK_Q_RES} fpk_qty_e;
   typedef enum logic [2:0] {FPK_D_VERSION, FPK_D_NORMAL, FPK_D_DEV, FPK_D_FREQ,
                             FPK_D_MENU, FPK_D_ERROR} fpk_disp_e;
   typedef enum logic {FPK_P_VERSION, FPK_P_RUN} fpk_phase_e;

   typedef struct packed {
      logic [21:0] meta;
      logic [21:0] sync;
      logic [21:0] last;
      logic [21:0] rise;
   } fpk_sync_s;

   typedef struct packed {
      // bus slave
      logic        awready;
      logic        wready;
      logic        aw_got;
      logic        w_got;
      logic [3:0]  waddr;
      logic        waddr_ok;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      // panel state
      fpk_phase_e  phase;
      logic [27:0] phase_cnt;
      logic [27:0] blink_cnt;
      logic        blink;
      logic [27:0] data_cnt;
      logic        shift;
      fpk_qty_e    qty;
      logic [2:0]  range;
      logic        ac;
      logic        neg;
      logic        dev_disp;
      logic        dev_nz;
      logic        freq_disp;
      logic        menu;
      logic [3:0]  err;
      logic [4:0]  evt_key;
      logic        evt_sec;
      logic        evt_pend;
      // registered outputs
      logic [19:0] led;
      logic [2:0]  vir;
      logic        data_led;
      logic        sock_hv;
      logic        sock_hc;
      logic        sock_lt;
      fpk_disp_e   disp;
   } fpk_state_s;
endpackage

// File: design/fpk_key_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for panel pins with rising-edge pulse
module fpk_key_sync
   import fpk_pkg::*;
(
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   // raw pins
   input  wire logic [21:0] pin_i,
   // synchronised levels and press pulses
   output logic      [21:0] level_o,
   output logic      [21:0] rise_o
);
   fpk_sync_s st;
   fpk_sync_s nxt;

   // meta feeds only the second stage
   always_comb begin
      nxt      = st;
      nxt.meta = pin_i;
      nxt.sync = st.meta;
      nxt.last = st.sync;
      nxt.rise = st.sync & ~st.last;
   end

   // state register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= nxt;
      end
   end

   assign level_o = st.sync;
   assign rise_o  = st.rise;
endmodule

// File: design/fpk_panel.sv
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "fpk_map.svh"
// Summary of operation
// - Local position: only panel buttons act, bus commands are ignored.
// - Remote position: only bus commands act, panel presses are ignored.
// - Twenty buttons in two rows, numbered 1-10 and 11-20, all but 10 and 20 with a light.
// - Button 11 arms shift and lights; next press takes secondary function.
// - Button 1 toggles deviation display or opens user menu; lit in deviation.
// - Button 1 light flashes when nominal shown but deviation nonzero.
// - Button 2 sets plus polarity or picks DC; lit while DC range used.
// - Buttons 3-8 bump digits or select one of six voltage ranges.
// - Button 9 bumps last digit or selects resistance; lit on resistance.
// - Button 10 sets full scale or confirms high-voltage interlock; no light.
// - Button 12 sets minus polarity or picks AC; lit while AC selected outside resistance.
// - Buttons 13-18 lower digits or select a current range, lit.
// - Button 19 lowers last digit or shows frequency/waveform, lit then.
// - Button 20 zeroes output or stores offset; no light.
// - Exactly one of voltage, current, resistance lights matches quantity.
// - Data light flashes per command-register write in remote, per press in local.
// - High-voltage sockets and light active only for high-voltage ranges.
// - High-current sockets and light active only for the top current range.
// - Low-thermal terminals for low voltage, low current and resistance.
// - Show version about one second, then lowest DC voltage range, zero.
// - Invalid calibration at power-up shows recalibration error code six.
module fpk_panel
   import fpk_pkg::*;
#(
   parameter logic [27:0] VERSION_CYCLES = 28'(`FPK_VERSION_MS * 1000 * `FPK_CLK_MHZ),
   parameter logic [27:0] BLINK_CYCLES   = 28'(`FPK_BLINK_MS * 1000 * `FPK_CLK_MHZ),
   parameter logic [27:0] DATA_CYCLES    = 28'(`FPK_DATA_MS * 1000 * `FPK_CLK_MHZ)
)(
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   // panel pins
   input  wire logic [19:0] key_i,
   input  wire logic        remote_sw_i,
   input  wire logic        cal_ok_i,
   // axi4-lite write
   input  wire logic [31:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   // axi4-lite read
   input  wire logic [31:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // indicators and sockets
   output logic [19:0]      key_led_o,
   output logic             volt_led_o,
   output logic             curr_led_o,
   output logic             res_led_o,
   output logic             data_led_o,
   output logic             hv_sock_o,
   output logic             hc_sock_o,
   output logic             lt_sock_o,
   output fpk_disp_e        disp_mode_o
);
   fpk_state_s  st;
   fpk_state_s  nxt;
   logic [21:0] pin_lvl;
   logic [21:0] pin_rise;
   logic        remote;
   logic [4:0]  key_num;
   logic        key_sec;
   logic        key_hit;
   logic        cmd_hit;
   logic        wr_fire;

   // lowest pressed key number, 0 when none
   function automatic logic [4:0] first_key(input logic [19:0] v);
      logic [4:0] k;
      k = 5'h0;
      for (int i = 19; i >= 0; i--) begin
         if (v[i]) begin
            k = 5'(i + 1);
         end
      end
      return k;
   endfunction

   // key inside an inclusive span
   function automatic logic in_span(input logic [4:0] k, input logic [4:0] lo, input logic [4:0] hi);
      return (k >= lo) && (k <= hi);
   endfunction

   // register map decode
   function automatic logic addr_ok(input logic [31:0] a);
      return (a[31:4] == 28'h0) && (a[1:0] == 2'h0);
   endfunction

   // pin synchroniser
   fpk_key_sync u_sync (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .pin_i   ({cal_ok_i, remote_sw_i, key_i}),
      .level_o (pin_lvl),
      .rise_o  (pin_rise)
   );

   assign remote = pin_lvl[`FPK_PIN_REMOTE];

   // next-state logic
   always_comb begin
      nxt     = st;
      key_num = 5'h0;
      key_sec = 1'b0;
      key_hit = 1'b0;
      cmd_hit = 1'b0;
      // write address and data, either order
      if (s_axi_awvalid_i && st.awready) begin
         nxt.aw_got   = 1'b1;
         nxt.waddr    = s_axi_awaddr_i[3:0];
         nxt.waddr_ok = addr_ok(s_axi_awaddr_i);
      end
      if (s_axi_wvalid_i && st.wready) begin
         nxt.w_got = 1'b1;
         nxt.wdata = s_axi_wdata_i;
         nxt.wstrb = s_axi_wstrb_i;
      end
      if (st.bvalid && s_axi_bready_i) begin
         nxt.bvalid = 1'b0;
      end
      wr_fire = st.aw_got && st.w_got && !st.bvalid;
      if (wr_fire) begin
         nxt.aw_got = 1'b0;
         nxt.w_got  = 1'b0;
         nxt.bvalid = 1'b1;
         nxt.bresp  = st.waddr_ok ? `FPK_RESP_OKAY : `FPK_RESP_SLVERR;
         if (st.waddr_ok && st.wstrb[0] && st.waddr == `FPK_ADDR_CTRL) begin
            nxt.dev_nz = st.wdata[`FPK_CTRL_DEVNZ];
         end
         if (st.waddr_ok && st.wstrb[1] && st.waddr == `FPK_ADDR_EVENT && st.wdata[`FPK_EVT_PEND]) begin
            nxt.evt_pend = 1'b0; // a new event below wins
         end
         // bus command only in remote position
         if (st.waddr_ok && st.wstrb[0] && st.waddr == `FPK_ADDR_CMD && remote) begin
            cmd_hit = 1'b1;
            if (st.phase == FPK_P_RUN && in_span(st.wdata[4:0], 5'h01, 5'h14)) begin
               key_num = st.wdata[4:0];
               key_sec = st.wdata[`FPK_CMD_SEC];
            end
         end
      end
      nxt.awready = !nxt.aw_got && !nxt.bvalid;
      nxt.wready  = !nxt.w_got && !nxt.bvalid;
      // read channel
      if (st.rvalid && s_axi_rready_i) begin
         nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && st.arready) begin
         nxt.rvalid = 1'b1;
         nxt.rresp  = addr_ok(s_axi_araddr_i) ? `FPK_RESP_OKAY : `FPK_RESP_SLVERR;
         nxt.rdata  = 32'h0;
         if (addr_ok(s_axi_araddr_i)) begin
            case (s_axi_araddr_i[3:0])
               `FPK_ADDR_CTRL:   nxt.rdata = {31'h0, st.dev_nz};
               `FPK_ADDR_STATUS: nxt.rdata = {12'h0, st.err, 1'b0, st.disp, remote, st.shift,
                                              st.menu, st.freq_disp, st.dev_disp, st.neg, st.ac,
                                              st.range, st.qty};
               `FPK_ADDR_EVENT:  nxt.rdata = {23'h0, st.evt_pend, 2'h0, st.evt_sec, st.evt_key};
               default:          nxt.rdata = 32'h0;
            endcase
         end
      end
      nxt.arready = !nxt.rvalid;
      // panel presses only in local position
      if (!remote && st.phase == FPK_P_RUN && |pin_rise[19:0]) begin
         key_hit = 1'b1;
         key_num = first_key(pin_rise[19:0]);
         if (key_num == `FPK_KEY_SHIFT) begin
            nxt.shift = 1'b1;
         end else begin
            key_sec   = st.shift;
            nxt.shift = 1'b0;
         end
      end
      // execute a decoded key
      if (key_num != 5'h0 && key_num != `FPK_KEY_SHIFT) begin
         nxt.evt_key  = key_num;
         nxt.evt_sec  = key_sec;
         nxt.evt_pend = 1'b1;
         case (key_num)
            5'h01: begin
               if (key_sec) begin
                  nxt.menu = 1'b1;
               end else begin
                  nxt.dev_disp = !st.dev_disp;
               end
            end
            5'h02: begin
               if (key_sec) begin
                  nxt.ac = 1'b0;
               end else begin
                  nxt.neg = 1'b0;
               end
            end
            5'h09: begin
               if (key_sec) begin
                  nxt.qty = FPK_Q_RES;
                  nxt.ac  = 1'b0;
               end
            end
            5'h0c: begin
               if (key_sec) begin
                  nxt.ac = 1'b1;
               end else begin
                  nxt.neg = 1'b1;
               end
            end
            5'h13: begin
               if (key_sec) begin
                  nxt.freq_disp = 1'b1;
               end
            end
            default: begin
               if (key_sec && in_span(key_num, 5'h03, 5'h08)) begin
                  nxt.qty       = FPK_Q_VOLT;
                  nxt.range     = 3'(5'h08 - key_num);
                  nxt.freq_disp = 1'b0;
                  nxt.menu      = 1'b0;
               end
               if (key_sec && in_span(key_num, 5'h0d, 5'h12)) begin
                  nxt.qty       = FPK_Q_CURR;
                  nxt.range     = 3'(5'h12 - key_num);
                  nxt.freq_disp = 1'b0;
                  nxt.menu      = 1'b0;
               end
            end
         endcase
      end
      // power-up version display then defaults
      if (st.phase == FPK_P_VERSION) begin
         nxt.phase_cnt = st.phase_cnt + 28'h1;
         if (st.phase_cnt == VERSION_CYCLES - 28'h1) begin
            nxt.phase     = FPK_P_RUN;
            nxt.qty       = FPK_Q_VOLT;
            nxt.range     = `FPK_RANGE_LOWEST;
            nxt.ac        = 1'b0;
            nxt.neg       = 1'b0;
            nxt.evt_key   = 5'h14; // zero output request
            nxt.evt_sec   = 1'b0;
            nxt.evt_pend  = 1'b1;
            nxt.err       = pin_lvl[`FPK_PIN_CAL_OK] ? 4'h0 : `FPK_CAL_ERR_CODE;
         end
      end
      // flash divider
      if (st.blink_cnt == BLINK_CYCLES - 28'h1) begin
         nxt.blink_cnt = 28'h0;
         nxt.blink     = !st.blink;
      end else begin
         nxt.blink_cnt = st.blink_cnt + 28'h1;
      end
      // data light one-shot
      if (key_hit || cmd_hit) begin
         nxt.data_cnt = DATA_CYCLES;
      end else if (st.data_cnt != 28'h0) begin
         nxt.data_cnt = st.data_cnt - 28'h1;
      end
      nxt.data_led = (nxt.data_cnt != 28'h0);
      // button lights
      nxt.led     = 20'h0;
      nxt.led[0]  = nxt.dev_disp || (nxt.dev_nz && nxt.blink);
      nxt.led[1]  = (nxt.qty != FPK_Q_RES) && !nxt.ac;
      for (int i = 0; i < 6; i++) begin
         nxt.led[7 - i]  = (nxt.qty == FPK_Q_VOLT) && (nxt.range == 3'(i));
         nxt.led[17 - i] = (nxt.qty == FPK_Q_CURR) && (nxt.range == 3'(i));
      end
      nxt.led[8]  = (nxt.qty == FPK_Q_RES);
      nxt.led[10] = nxt.shift;
      nxt.led[11] = (nxt.qty != FPK_Q_RES) && nxt.ac;
      nxt.led[18] = nxt.freq_disp;
      // quantity lights and sockets
      nxt.vir     = {nxt.qty == FPK_Q_RES, nxt.qty == FPK_Q_CURR, nxt.qty == FPK_Q_VOLT};
      nxt.sock_hv = (nxt.qty == FPK_Q_VOLT) && (nxt.range >= `FPK_VR_HV_FIRST);
      nxt.sock_hc = (nxt.qty == FPK_Q_CURR) && (nxt.range >= `FPK_IR_HC_FIRST);
      nxt.sock_lt = !nxt.sock_hv && !nxt.sock_hc;
      // display mode
      if (nxt.phase == FPK_P_VERSION) begin
         nxt.disp = FPK_D_VERSION;
      end else if (nxt.err != 4'h0) begin
         nxt.disp = FPK_D_ERROR;
      end else if (nxt.freq_disp) begin
         nxt.disp = FPK_D_FREQ;
      end else if (nxt.menu) begin
         nxt.disp = FPK_D_MENU;
      end else if (nxt.dev_disp) begin
         nxt.disp = FPK_D_DEV;
      end else begin
         nxt.disp = FPK_D_NORMAL;
      end
   end

   // state register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st         <= '0;
         st.vir     <= 3'h1;
         st.sock_lt <= 1'b1;
         st.led     <= 20'h00082;
      end else begin
         st <= nxt;
      end
   end

   // outputs straight from state
   assign s_axi_awready_o = st.awready;
   assign s_axi_wready_o  = st.wready;
   assign s_axi_bresp_o   = st.bresp;
   assign s_axi_bvalid_o  = st.bvalid;
   assign s_axi_arready_o = st.arready;
   assign s_axi_rdata_o   = st.rdata;
   assign s_axi_rresp_o   = st.rresp;
   assign s_axi_rvalid_o  = st.rvalid;
   assign key_led_o       = st.led;
   assign volt_led_o      = st.vir[0];
   assign curr_led_o      = st.vir[1];
   assign res_led_o       = st.vir[2];
   assign data_led_o      = st.data_led;
   assign hv_sock_o       = st.sock_hv;
   assign hc_sock_o       = st.sock_hc;
   assign lt_sock_o       = st.sock_lt;
   assign disp_mode_o     = st.disp;

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   AST_LOCAL_NO_BUS: assert property (!remote && !key_hit |=> $stable(st.qty) && $stable(st.range))
      else $error("bus changed range in local mode");
   AST_REMOTE_NO_KEYS: assert property (remote |=> !$rose(st.shift))
      else $error("shift armed in remote mode");
   AST_SHIFT_ONCE: assert property (key_hit && key_sec |=> !st.shift && !key_led_o[10])
      else $error("shift not cleared after secondary press");
   AST_DEV_FLASH: assert property (!st.dev_disp && !st.dev_nz |-> !key_led_o[0])
      else $error("deviation light lit without deviation");
   AST_VRANGE_ONEHOT: assert property (st.qty == FPK_Q_VOLT |-> $onehot(key_led_o[7:2]))
      else $error("voltage range lights not one-hot");
   AST_QTY_ONEHOT: assert property ($onehot({res_led_o, curr_led_o, volt_led_o}))
      else $error("quantity lights not one-hot");
   AST_DATA_PULSE: assert property (key_hit || cmd_hit |=> data_led_o [*2])
      else $error("data light did not flash");
   AST_HV_SOCK: assert property (hv_sock_o |-> volt_led_o && st.range >= `FPK_VR_HV_FIRST)
      else $error("high-voltage sockets active off range");
   AST_HC_SOCK: assert property (hc_sock_o |-> curr_led_o && st.range == `FPK_IR_HC_FIRST)
      else $error("high-current sockets active off range");
   AST_SOCK_ONEHOT: assert property ($onehot({hv_sock_o, hc_sock_o, lt_sock_o}))
      else $error("socket selection not one-hot");
   AST_POWER_UP: assert property ($rose(st.phase == FPK_P_RUN) |-> st.range == 3'h0 && volt_led_o && !st.ac)
      else $error("power-up default range wrong");
   AST_CAL_ERR: assert property ($rose(st.phase == FPK_P_RUN) && !pin_lvl[21] |=> st.err == 4'h6)
      else $error("calibration error code missing");

   COV_SHIFT_RANGE: cover property (key_hit && key_sec && in_span(key_num, 5'h03, 5'h08));
   COV_REMOTE_CMD:  cover property (cmd_hit && key_num != 5'h0);
   COV_HV_SOCK:     cover property ($rose(hv_sock_o));
endmodule

// File: tb/fpk_operator.sv
`timescale 1ns/10ps
// operator at the panel: presses one button for a few clocks, then lets go
module fpk_operator (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   // press request, button number 1..20
   input  wire logic        go_i,
   input  wire logic [4:0]  btn_i,
   // raw button pins
   output logic      [19:0] key_o
);
   logic [2:0] hold_ff;

   // bit i is button i+1, held long enough to pass the synchroniser
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         key_o   <= 20'h0;
         hold_ff <= 3'h0;
      end else if (go_i) begin
         key_o   <= 20'h1 << (btn_i - 5'h1);
         hold_ff <= 3'h4;
      end else if (hold_ff != 3'h0) begin
         hold_ff <= hold_ff - 3'h1;
         if (hold_ff == 3'h1) key_o <= 20'h0; // release between presses
      end
   end
endmodule

// File: tb/front_panel_key_controller_test.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module front_panel_key_controller_test
   import fpk_pkg::*;
;
   logic        clock_i, rst_b_i, remote_sw_i, cal_ok_i, go, seen_data;
   logic [4:0]  btn;
   logic [19:0] key, key_led;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic        volt, curr, res, data_led, hv, hc, lt;
   logic [31:0] rd;
   fpk_disp_e   disp;
   int          n_errors, tests_run;

   fpk_panel #(.VERSION_CYCLES(28'd20), .BLINK_CYCLES(28'd4), .DATA_CYCLES(28'd3)) DUT (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .key_i(key), .remote_sw_i(remote_sw_i), .cal_ok_i(cal_ok_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .key_led_o(key_led), .volt_led_o(volt), .curr_led_o(curr), .res_led_o(res), .data_led_o(data_led),
      .hv_sock_o(hv), .hc_sock_o(hc), .lt_sock_o(lt), .disp_mode_o(disp));
   fpk_operator OPER (.clock_i(clock_i), .rst_b_i(rst_b_i), .go_i(go), .btn_i(btn), .key_o(key));

   // 200 mhz clock
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   // remembers any flash of the data light
   always @(posedge clock_i) if (data_led === 1'b1) seen_data <= 1'b1;

   task automatic final_report();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic do_reset();
      rst_b_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      rst_b_i <= 1'b1;
   endtask
   // press one button, then wait past the decode latency
   task automatic press(input logic [4:0] b);
      btn <= b;
      go  <= 1'b1;
      @(posedge clock_i);
      go  <= 1'b0;
      repeat (10) @(posedge clock_i);
   endtask
   // one write, channels released as each is taken
   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      int i;
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      i = 0;
      do begin
         @(posedge clock_i);
         i++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && i < 40);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clock_i); // keeps this release apart from the next request
      if (i >= 40) begin n_errors++; final_report(); end
   endtask
   task automatic axr(input logic [31:0] a);
      int i;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      i = 0;
      do begin
         @(posedge clock_i);
         i++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && i < 40);
      resp = rresp; rd = rdata;
      rready <= 1'b0;
      @(posedge clock_i); // keeps this release apart from the next request
      if (i >= 40) begin n_errors++; final_report(); end
   endtask

   // reset state, version phase, then default range
   task automatic t_power_up();
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      `CHK("rst outs", {20'h00082, 6'b100001}, {key_led, volt, curr, res, hv, hc, lt})
      `CHK("rst disp", FPK_D_VERSION, disp)
      rst_b_i <= 1'b1;
      repeat (30) @(posedge clock_i);
      `CHK("run disp", FPK_D_NORMAL, disp)
      axr(32'h8);
      `CHK("zero evt", 32'h114, rd)
      `CHK("run outs", {20'h00082, 6'b100001}, {key_led, volt, curr, res, hv, hc, lt})
   endtask
   // shift then top voltage range, then top current range
   task automatic t_shift_ranges();
      press(5'd11);
      `CHK("shift led", 20'h00482, key_led)
      press(5'd3);
      `CHK("1kv outs", {20'h00006, 6'b100100}, {key_led, volt, curr, res, hv, hc, lt})
      press(5'd11);
      press(5'd13);
      `CHK("10a outs", {20'h01002, 6'b010010}, {key_led, volt, curr, res, hv, hc, lt})
   endtask
   // resistance, then a primary press that leaves the lights alone
   task automatic t_res_primary();
      press(5'd11);
      press(5'd9);
      `CHK("res outs", {20'h00100, 6'b001001}, {key_led, volt, curr, res, hv, hc, lt})
      seen_data <= 1'b0;
      press(5'd12);
      `CHK("prim leds", 20'h00100, key_led)
      `CHK("press data", 1'b1, seen_data)
   endtask
   // remote ignores panel, obeys bus; local ignores bus
   task automatic t_remote();
      remote_sw_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      press(5'd11);
      press(5'd3);
      `CHK("rem panel", 20'h00100, key_led)
      seen_data <= 1'b0;
      axw(32'hc, 32'h23);
      repeat (4) @(posedge clock_i);
      `CHK("cmd resp", 2'h0, resp)
      `CHK("cmd outs", {20'h00006, 6'b100100}, {key_led, volt, curr, res, hv, hc, lt})
      `CHK("bus data", 1'b1, seen_data)
      remote_sw_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      axw(32'hc, 32'h2d);
      repeat (4) @(posedge clock_i);
      `CHK("loc cmd", 20'h00006, key_led)
   endtask
   // status fields, unmapped place, frequency display
   task automatic t_bus_freq();
      axr(32'h4);
      `CHK("stat range", 5'h14, rd[4:0])
      axr(32'h10);
      `CHK("unmapped", 34'h200000000, {resp, rd})
      press(5'd11);
      press(5'd19);
      `CHK("freq disp", FPK_D_FREQ, disp)
      `CHK("freq led", 1'b1, key_led[18])
   endtask
   // deviation flash, deviation and menu display, events, ac/dc lights
   task automatic t_deviation();
      logic [4:0] ones;
      ones = 5'h0;
      press(5'd11);
      press(5'd8);
      axw(32'h0, 32'h1);
      repeat (16) begin
         @(posedge clock_i);
         ones = ones + 5'(key_led[0]);
      end
      `CHK("dev flash", 5'd8, ones)
      press(5'd1);
      `CHK("dev disp", FPK_D_DEV, disp)
      `CHK("dev leds", 20'h00083, key_led)
      press(5'd11);
      press(5'd1);
      `CHK("menu disp", FPK_D_MENU, disp)
      axr(32'h8);
      `CHK("menu evt", 32'h121, rd)
      press(5'd10);
      axr(32'h8);
      `CHK("fs evt", 32'h10a, rd)
      axw(32'h8, 32'h100);
      axr(32'h8);
      `CHK("evt clear", 32'h00a, rd)
      press(5'd11);
      press(5'd12);
      `CHK("ac leds", 20'h00881, key_led)
      press(5'd11);
      press(5'd2);
      `CHK("dc leds", 20'h00083, key_led)
   endtask
   // lost calibration seen at power-up
   task automatic t_cal_lost();
      cal_ok_i <= 1'b0;
      do_reset();
      repeat (30) @(posedge clock_i);
      `CHK("err disp", FPK_D_ERROR, disp)
      axr(32'h4);
      `CHK("err code", 4'h6, rd[19:16])
   endtask

   // main sequence
   initial begin
      rst_b_i = 1'b0; remote_sw_i = 1'b0; cal_ok_i = 1'b1; go = 1'b0; btn = 5'h0; seen_data = 1'b0;
      awaddr = 32'h0; wdata = 32'h0; wstrb = 4'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      araddr = 32'h0; arvalid = 1'b0; rready = 1'b0; n_errors = 0; tests_run = 0;
      repeat (2) @(posedge clock_i);
      t_power_up();
      t_shift_ranges();
      t_res_primary();
      t_remote();
      t_bus_freq();
      t_deviation();
      t_cal_lost();
      final_report();
   end
endmodule
